// ---- src/ldc_pkg.sv ----
// Constants shared by the LED driver control block and its bench.
// Assumes: a byte-wide two-wire target link and four byte-wide control registers.
`default_nettype none
package ldc_pkg;
	// ------------------------------------------------------------
	// Link addressing
	// ------------------------------------------------------------
	localparam logic [6:0] TARGET_ADDR = 7'h36;
	localparam logic DIR_READ = 1'b1;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// ------------------------------------------------------------
	// Register offsets and power-on values
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_GENERAL = 8'h10;
	localparam logic [7:0] OFS_IO_CFG = 8'h80;
	localparam logic [7:0] OFS_PRIMARY = 8'hA0;
	localparam logic [7:0] OFS_SECONDARY = 8'hB0;
	localparam logic [7:0] RST_GENERAL = 8'hC0;
	localparam logic [7:0] RST_IO_CFG = 8'hF8;
	localparam logic [7:0] RST_LEVEL = 8'hE0;
	localparam logic [7:0] PIN_RESET_VALUE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_PRIMARY_EN = 0;
	localparam int BIT_SECONDARY_EN = 1;
	localparam int BIT_SHARED_LEVEL = 2;
	localparam int BIT_STEP_LOW = 3;
	localparam int BIT_STEP_HIGH = 4;
	localparam int BIT_DISPLAY_BIAS = 5;
	localparam int GENERAL_STORED_W = 6;
	localparam logic [1:0] GENERAL_FIXED_ONES = 2'h3;
	localparam int IO_BIT_MODE = 0;
	localparam int IO_BIT_DIR = 1;
	localparam int IO_BIT_VALUE = 2;
	localparam int LEVEL_W = 5;

	// ------------------------------------------------------------
	// Link phases
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_REG,
		LINK_WDATA,
		LINK_RDATA,
		LINK_HOLD
	} ldc_link_state_t;
endpackage
`default_nettype wire

// ---- src/ldc_sync.sv ----
// Two-stage synchroniser for a level or a quasi-static word.
// Assumes: the word changes rarely and stays stable for several destination clocks.
`timescale 1ns/10ps
`default_nettype none
module ldc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk, // Destination clock
	input wire logic i_rst, // Asynchronous reset, active high
	input wire logic [W-1:0] i_d, // Value from the other domain
	output logic [W-1:0] o_q // Synchronised value
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ldc_sync_t;

	ldc_sync_t st_r;
	ldc_sync_t st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt.s1 = i_d;
		st_nxt.s2 = st_r.s1;
	end

	// Register both stages
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_q = st_r.s2;
endmodule
`default_nettype wire

// ---- src/ldc_ctrl.sv ----
// LED driver control: two-wire target link and the control registers it writes.
// Assumes: i_scl is the link master's clock, the pull-ups and wire levels are resolved
// outside, and the analog sinks follow the enable and level outputs.
//
// What this block does
// R1 - Shared select clear: primary sink uses primary level, secondary uses secondary level.
// R2 - Shared select set: both sinks follow the primary level and, outside display-bias mode, the primary enable.
// R3 - After power-up the dual pin acts as active-low reset input.
// R4 - Reset mode, pin low: every register clears to 0x00 (general reads 0xC0), writes refused.
// R5 - Pin config register is eight bits, only three low bits act.
// R6 - Dual pin as output is open drain, only pulls low.
// R7 - Master makes every START and STOP on the bus.
// R8 - Bus busy from START to STOP; repeated START same as START.
// R9 - Data line changes only while clock low, stable while high.
// R10 - Answer only target address 0x36 in first byte after START.
// R11 - Eighth address bit: 0 write, 1 read.
// R12 - Write: second byte is register address, third byte is data.
// R13 - Bytes are eight bits, MSB first, then one acknowledge bit.
// R14 - Device pulls data low in ninth pulse after each received byte.
// R15 - General bit 0 enables primary sink; clear leaves it off.
// R16 - General bit 1 enables secondary sink; clear leaves it off unless shared select set.
// R17 - General bits 3 and 4 select the brightness step rate.
// R18 - General bit 5 selects display-bias mode, secondary becomes feedback.
// R19 - General bits 6 and 7 ignore writes, always read 1.
// R20 - Only five low bits of each level register set current.
// R21 - Analog section on when either sink enable or display mode set.
// R22 - Reads return last addressed register MSB first; release on no acknowledge.
// R23 - Power-on loads initial values: sinks off, white-LED, independent levels.
`timescale 1ns/10ps
`default_nettype none
module ldc_ctrl (
	input wire logic i_clk, // System clock, 20 MHz
	input wire logic i_rst, // Asynchronous power-on reset, active high
	input wire logic i_scl, // Link clock from the master
	input wire logic i_sda, // Link data line level
	output logic o_sda_out, // Link data drive value, always low
	output logic o_sda_oe, // High while pulling the data line low
	input wire logic i_rstio, // Dual reset/IO pin level
	output logic o_rstio_out, // Dual pin drive value, always low
	output logic o_rstio_oe, // High while pulling the dual pin low
	output logic o_primary_sink_enable, // Primary sink on
	output logic o_secondary_sink_enable, // Secondary sink on
	output logic [4:0] o_primary_level, // Primary sink current code
	output logic [4:0] o_secondary_level, // Secondary sink current code
	output logic [1:0] o_step_rate, // Brightness step rate select
	output logic o_display_bias_mode, // Secondary pin used as feedback
	output logic o_analog_enable, // Analog section powered
	output logic o_pin_reset_active // Registers held by the dual pin
);
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		ldc_pkg::ldc_link_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rd;
		logic [7:0] ptr;
		logic [7:0] wa;
		logic [7:0] wd;
		logic wt;
		logic [7:0] tx;
		logic st_seen;
		logic sp_seen;
	} ldc_link_t;

	typedef struct packed {
		logic [5:0] gc;
		logic [7:0] io;
		logic [7:0] pl;
		logic [7:0] sl;
		logic wseen;
		logic [7:0] rb;
		logic pen;
		logic sen;
		logic [4:0] plv;
		logic [4:0] slv;
		logic [1:0] rate;
		logic disp;
		logic ana;
		logic poe;
		logic prst;
	} ldc_ctl_t;

	localparam ldc_ctl_t CTL_RST = '{
		gc: ldc_pkg::RST_GENERAL[5:0],
		io: ldc_pkg::RST_IO_CFG,
		pl: ldc_pkg::RST_LEVEL,
		sl: ldc_pkg::RST_LEVEL,
		default: '0
	};

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	ldc_link_t l_r;
	ldc_link_t l_nxt;
	ldc_ctl_t c_r;
	ldc_ctl_t c_nxt;
	logic start_tog_r;
	logic stop_tog_r;
	logic sda_oe_r;
	logic sda_oe_nxt;
	logic [7:0] byte_in;
	logic [7:0] rd_byte_s;
	logic wt_s;
	logic [7:0] ptr_s;
	logic pin_s;
	logic pin_hold;
	logic [7:0] io_view;

	// ------------------------------------------------------------
	// Start and stop detection
	// ------------------------------------------------------------
	// Data falling while clock high marks a start, repeated or not
	always_ff @(negedge i_sda or posedge i_rst) begin
		if (i_rst) begin
			start_tog_r <= 1'b0;
		end else if (i_scl) begin
			start_tog_r <= ~start_tog_r; // R7 R8
		end
	end

	// Data rising while clock high marks a stop
	always_ff @(posedge i_sda or posedge i_rst) begin
		if (i_rst) begin
			stop_tog_r <= 1'b0;
		end else if (i_scl) begin
			stop_tog_r <= ~stop_tog_r; // R7 R8
		end
	end

	// ------------------------------------------------------------
	// Link logic on the link clock
	// ------------------------------------------------------------
	// Byte being completed by the bit on the line now
	assign byte_in = {l_r.sh[6:0], i_sda}; // R13

	// Bit sampling on the rising clock, where data is stable
	always_comb begin
		l_nxt = l_r;
		if (start_tog_r != l_r.st_seen) begin
			// A start also absorbs any stop seen before it
			l_nxt.st_seen = start_tog_r; // R8
			l_nxt.sp_seen = stop_tog_r;
			l_nxt.st = ldc_pkg::LINK_ADDR;
			l_nxt.cnt = 4'h1;
			l_nxt.sh = byte_in;
		end else if (stop_tog_r != l_r.sp_seen) begin
			l_nxt.sp_seen = stop_tog_r; // R8
			l_nxt.st = ldc_pkg::LINK_IDLE;
			l_nxt.cnt = 4'h0;
		end else begin
			case (l_r.st)
				ldc_pkg::LINK_ADDR, ldc_pkg::LINK_REG, ldc_pkg::LINK_WDATA: begin
					if (l_r.cnt == ldc_pkg::ACK_SLOT) begin
						// Acknowledge clock ends, pick the next phase
						l_nxt.cnt = 4'h0;
						if (l_r.st == ldc_pkg::LINK_ADDR) begin
							if (l_r.rd == ldc_pkg::DIR_READ) begin
								l_nxt.st = ldc_pkg::LINK_RDATA; // R11
								l_nxt.tx = rd_byte_s; // R22
							end else begin
								l_nxt.st = ldc_pkg::LINK_REG; // R12
							end
						end else begin
							l_nxt.st = ldc_pkg::LINK_WDATA; // R12
						end
					end else begin
						l_nxt.sh = byte_in; // R13
						l_nxt.cnt = l_r.cnt + 4'h1;
						if (l_r.cnt == ldc_pkg::LAST_DATA_BIT) begin
							case (l_r.st)
								ldc_pkg::LINK_ADDR: begin
									if (byte_in[7:1] != ldc_pkg::TARGET_ADDR) begin
										l_nxt.st = ldc_pkg::LINK_HOLD; // R10
									end
									l_nxt.rd = byte_in[0]; // R11
								end
								ldc_pkg::LINK_REG: begin
									l_nxt.ptr = byte_in; // R12
								end
								default: begin
									// Data byte: hand the write to the system clock
									l_nxt.wa = l_r.ptr; // R12
									l_nxt.wd = byte_in;
									l_nxt.wt = ~l_r.wt;
								end
							endcase
						end
					end
				end
				ldc_pkg::LINK_RDATA: begin
					if (l_r.cnt == ldc_pkg::ACK_SLOT) begin
						l_nxt.cnt = 4'h0;
						if (i_sda) begin
							l_nxt.st = ldc_pkg::LINK_HOLD; // R22
						end else begin
							l_nxt.tx = rd_byte_s; // R22
						end
					end else begin
						l_nxt.tx = {l_r.tx[6:0], 1'b0}; // R13
						l_nxt.cnt = l_r.cnt + 4'h1;
					end
				end
				default: begin
					l_nxt.cnt = 4'h0;
				end
			endcase
		end
	end

	// Link state register
	always_ff @(posedge i_scl or posedge i_rst) begin
		if (i_rst) begin
			l_r <= '{st: ldc_pkg::LINK_IDLE, default: '0};
		end else begin
			l_r <= l_nxt;
		end
	end

	// Data drive decided from the phase reached at the last rising clock
	always_comb begin
		case (l_r.st)
			ldc_pkg::LINK_ADDR, ldc_pkg::LINK_REG, ldc_pkg::LINK_WDATA: begin
				sda_oe_nxt = (l_r.cnt == ldc_pkg::ACK_SLOT); // R14
			end
			ldc_pkg::LINK_RDATA: begin
				sda_oe_nxt = (l_r.cnt != ldc_pkg::ACK_SLOT) && !l_r.tx[7]; // R22
			end
			default: begin
				sda_oe_nxt = 1'b0;
			end
		endcase
	end

	// Data drive changes only on the falling clock
	always_ff @(negedge i_scl or posedge i_rst) begin
		if (i_rst) begin
			sda_oe_r <= 1'b0;
		end else begin
			sda_oe_r <= sda_oe_nxt; // R9
		end
	end

	assign o_sda_oe = sda_oe_r;
	assign o_sda_out = 1'b0;

	// ------------------------------------------------------------
	// Crossings
	// ------------------------------------------------------------
	// Write event toggle into the system clock
	ldc_sync #(.W(1), .RST_VAL(1'b0)) u_wt_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(l_r.wt),
		.o_q(wt_s)
	);

	// Register pointer, stable from its byte until the read begins
	ldc_sync #(.W(8), .RST_VAL(8'h00)) u_ptr_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(l_r.ptr),
		.o_q(ptr_s)
	);

	// Read byte back onto the link clock
	ldc_sync #(.W(8), .RST_VAL(8'h00)) u_rb_sync (
		.i_clk(i_scl),
		.i_rst(i_rst),
		.i_d(c_r.rb),
		.o_q(rd_byte_s)
	);

	// Dual pin level, released high at reset
	ldc_sync #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(i_rstio),
		.o_q(pin_s)
	);

	// ------------------------------------------------------------
	// Register file on the system clock
	// ------------------------------------------------------------
	// Pin holds the registers only while in reset mode
	assign pin_hold = !c_r.io[ldc_pkg::IO_BIT_MODE] && !pin_s; // R3 R4

	// Pin config as read: value bit shows the pin level when used as input
	always_comb begin
		io_view = c_r.io; // R5
		if (c_r.io[ldc_pkg::IO_BIT_MODE] && !c_r.io[ldc_pkg::IO_BIT_DIR]) begin
			io_view[ldc_pkg::IO_BIT_VALUE] = pin_s;
		end
	end

	// Writes, pin reset, read select and sink outputs
	always_comb begin
		c_nxt = c_r;
		c_nxt.wseen = wt_s;
		if (pin_hold) begin
			// Writes arriving now are dropped
			c_nxt.gc = ldc_pkg::PIN_RESET_VALUE[5:0]; // R4
			c_nxt.io = ldc_pkg::PIN_RESET_VALUE;
			c_nxt.pl = ldc_pkg::PIN_RESET_VALUE;
			c_nxt.sl = ldc_pkg::PIN_RESET_VALUE;
		end else if (wt_s != c_r.wseen) begin
			case (l_r.wa)
				ldc_pkg::OFS_GENERAL: begin
					c_nxt.gc = l_r.wd[5:0]; // R19
				end
				ldc_pkg::OFS_IO_CFG: begin
					c_nxt.io = l_r.wd; // R5
				end
				ldc_pkg::OFS_PRIMARY: begin
					c_nxt.pl = l_r.wd;
				end
				ldc_pkg::OFS_SECONDARY: begin
					c_nxt.sl = l_r.wd;
				end
				default: begin
					c_nxt.gc = c_r.gc;
				end
			endcase
		end
		case (ptr_s)
			ldc_pkg::OFS_GENERAL: begin
				c_nxt.rb = {ldc_pkg::GENERAL_FIXED_ONES, c_r.gc}; // R19 R22
			end
			ldc_pkg::OFS_IO_CFG: begin
				c_nxt.rb = io_view;
			end
			ldc_pkg::OFS_PRIMARY: begin
				c_nxt.rb = c_r.pl;
			end
			ldc_pkg::OFS_SECONDARY: begin
				c_nxt.rb = c_r.sl;
			end
			default: begin
				c_nxt.rb = ldc_pkg::UNMAPPED_READ;
			end
		endcase
		// Sink controls follow the new register values
		c_nxt.pen = c_nxt.gc[ldc_pkg::BIT_PRIMARY_EN]; // R15
		if (c_nxt.gc[ldc_pkg::BIT_DISPLAY_BIAS]) begin
			c_nxt.sen = 1'b0; // R18
		end else if (c_nxt.gc[ldc_pkg::BIT_SHARED_LEVEL]) begin
			c_nxt.sen = c_nxt.gc[ldc_pkg::BIT_PRIMARY_EN]; // R2
		end else begin
			c_nxt.sen = c_nxt.gc[ldc_pkg::BIT_SECONDARY_EN]; // R16 R1
		end
		c_nxt.plv = c_nxt.pl[ldc_pkg::LEVEL_W-1:0]; // R1 R20
		if (c_nxt.gc[ldc_pkg::BIT_SHARED_LEVEL]) begin
			c_nxt.slv = c_nxt.pl[ldc_pkg::LEVEL_W-1:0]; // R2 R20
		end else begin
			c_nxt.slv = c_nxt.sl[ldc_pkg::LEVEL_W-1:0]; // R1 R20
		end
		c_nxt.rate = {c_nxt.gc[ldc_pkg::BIT_STEP_HIGH], c_nxt.gc[ldc_pkg::BIT_STEP_LOW]}; // R17
		c_nxt.disp = c_nxt.gc[ldc_pkg::BIT_DISPLAY_BIAS]; // R18
		c_nxt.ana = c_nxt.gc[ldc_pkg::BIT_PRIMARY_EN] | c_nxt.gc[ldc_pkg::BIT_SECONDARY_EN]
			| c_nxt.gc[ldc_pkg::BIT_DISPLAY_BIAS]; // R21
		c_nxt.poe = c_nxt.io[ldc_pkg::IO_BIT_MODE] && c_nxt.io[ldc_pkg::IO_BIT_DIR]
			&& !c_nxt.io[ldc_pkg::IO_BIT_VALUE]; // R6
		c_nxt.prst = pin_hold; // R4
	end

	// System state register, power-on values
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			c_r <= CTL_RST; // R23 R3
		end else begin
			c_r <= c_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_primary_sink_enable = c_r.pen;
	assign o_secondary_sink_enable = c_r.sen;
	assign o_primary_level = c_r.plv;
	assign o_secondary_level = c_r.slv;
	assign o_step_rate = c_r.rate;
	assign o_display_bias_mode = c_r.disp;
	assign o_analog_enable = c_r.ana;
	assign o_rstio_oe = c_r.poe;
	assign o_rstio_out = 1'b0;
	assign o_pin_reset_active = c_r.prst;
endmodule
`default_nettype wire

// ---- verif/ldc_ctrl_asserts.sv ----
// Checker for the LED driver control block, bound to its ports.
// Assumes: i_clk system domain, i_scl link domain, i_rst async high for both.
`timescale 1ns/10ps
`default_nettype none
module ldc_ctrl_asserts (
	input wire logic i_clk, // System clock
	input wire logic i_rst, // Reset, active high
	input wire logic i_scl, // Link clock
	input wire logic i_rstio, // Dual pin level
	input wire logic o_sda_out, // Data drive value
	input wire logic o_sda_oe, // Data pull enable
	input wire logic o_rstio_out, // Dual pin drive value
	input wire logic o_rstio_oe, // Dual pin pull enable
	input wire logic o_primary_sink_enable, // Primary sink on
	input wire logic o_secondary_sink_enable, // Secondary sink on
	input wire logic [4:0] o_primary_level, // Primary code
	input wire logic [1:0] o_step_rate, // Step rate
	input wire logic o_display_bias_mode, // Feedback mode
	input wire logic o_analog_enable, // Analog on
	input wire logic o_pin_reset_active // Pin hold
);
	logic [4:0] lo_hist;
	logic oe_rise;
	// ----------------------------------------
	// Helper history
	// ----------------------------------------
	// Recent low samples of the dual pin
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) lo_hist <= '0;
		else lo_hist <= {lo_hist[3:0], !i_rstio};
	end
	// Data drive as seen at each link clock rise
	always_ff @(posedge i_scl or posedge i_rst) begin
		if (i_rst) oe_rise <= 1'b0;
		else oe_rise <= o_sda_oe;
	end
	sequence pin_high_s;
		i_rstio [*5];
	endsequence
	sequence link_idle_s;
		i_scl [*4];
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sda_drive_low_a: assert property (
		@(posedge i_clk) disable iff (i_rst) o_sda_oe |-> !o_sda_out) else $error("data drive high");
	pin_drive_low_a: assert property (
		@(posedge i_clk) disable iff (i_rst) o_rstio_oe |-> !o_rstio_out) else $error("pin drive high");
	analog_on_a: assert property (
		@(posedge i_clk) disable iff (i_rst) (o_primary_sink_enable || o_secondary_sink_enable
		|| o_display_bias_mode) |-> o_analog_enable) else $error("analog off");
	bias_sub_off_a: assert property (
		@(posedge i_clk) disable iff (i_rst) o_display_bias_mode |-> !o_secondary_sink_enable)
		else $error("secondary on in bias mode");
	pin_hold_zero_a: assert property (
		@(posedge i_clk) disable iff (i_rst) o_pin_reset_active && $past(o_pin_reset_active)
		|-> !o_analog_enable && o_primary_level == 5'h00 && o_step_rate == 2'h0)
		else $error("outputs not cleared in hold");
	pin_hold_cause_a: assert property (
		@(posedge i_clk) disable iff (i_rst) o_pin_reset_active |-> (|lo_hist))
		else $error("hold without low pin");
	pin_release_a: assert property (
		@(posedge i_clk) disable iff (i_rst) pin_high_s |=> !o_pin_reset_active)
		else $error("hold after pin high");
	oe_hold_high_a: assert property (
		@(negedge i_scl) disable iff (i_rst) o_sda_oe == oe_rise) else $error("data moved in high");
	idle_release_a: assert property (
		@(posedge i_clk) disable iff (i_rst) link_idle_s |-> !o_sda_oe) else $error("idle bus held");
endmodule
bind ldc_ctrl ldc_ctrl_asserts CHK (.i_clk, .i_rst, .i_scl, .i_rstio, .o_sda_out, .o_sda_oe,
	.o_rstio_out, .o_rstio_oe, .o_primary_sink_enable, .o_secondary_sink_enable,
	.o_primary_level, .o_step_rate, .o_display_bias_mode, .o_analog_enable, .o_pin_reset_active);
`default_nettype wire

// ---- verif/ldc_i2c_master.sv ----
// Two-wire link master model: START, STOP and byte transfers, 32 ns bit clock.
// Assumes: open-drain data line with pull-up resolved outside; clock stands high idle.
`timescale 1ns/10ps
`default_nettype none
module ldc_i2c_master (
	output logic o_scl, // Link clock, still outside frames
	output logic o_sda_low, // High while pulling data low
	input wire logic i_sda // Resolved data level
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	// Data falls while clock high
	task automatic start();
		#8 o_sda_low = 1'b0;
		#8 o_scl = 1'b1;
		#8 o_sda_low = 1'b1;
		#8 o_scl = 1'b0;
	endtask
	// Data rises while clock high
	task automatic stop();
		#8 o_sda_low = 1'b1;
		#8 o_scl = 1'b1;
		#8 o_sda_low = 1'b0;
		#8;
	endtask
	// Data set in low phase, sampled mid high phase
	task automatic clk_bit(input logic b, output logic s);
		#8 o_sda_low = !b;
		#8 o_scl = 1'b1;
		#8 s = i_sda;
		#8 o_scl = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(a, k);
	endtask
endmodule
`default_nettype wire

// ---- verif/test_led_driver_i2c_control_regs.sv ----
// Self-checking bench for the LED driver control block.
// Assumes: link master model and checker compiled before this file.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module test_led_driver_i2c_control_regs;
	logic i_clk, i_rst, pin_low_r, ak;
	logic [7:0] q;
	int err_total, n_checks;
	wire logic i_scl, m_low, o_sda_out, o_sda_oe, o_rstio_out, o_rstio_oe, o_analog_enable;
	wire logic o_primary_sink_enable, o_secondary_sink_enable, o_display_bias_mode;
	wire logic o_pin_reset_active;
	wire logic [4:0] o_primary_level, o_secondary_level;
	wire logic [1:0] o_step_rate;
	wire logic i_sda = !m_low && !(o_sda_oe && !o_sda_out);
	wire logic i_rstio = !pin_low_r && !(o_rstio_oe && !o_rstio_out);
	logic [7:0] gv [8] = '{8'h01, 8'h02, 8'h05, 8'h03, 8'h18, 8'h21, 8'h00, 8'hFF};
	ldc_ctrl DUT (.i_clk, .i_rst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_rstio, .o_rstio_out,
		.o_rstio_oe, .o_primary_sink_enable, .o_secondary_sink_enable, .o_primary_level,
		.o_secondary_level, .o_step_rate, .o_display_bias_mode, .o_analog_enable,
		.o_pin_reset_active);
	ldc_i2c_master LNK (.o_scl(i_scl), .o_sda_low(m_low), .i_sda(i_sda));
	// ----------------------------------------
	// Link transfers
	// ----------------------------------------
	// Address, register, data; ok is all three acknowledged
	task automatic wr(input logic [6:0] a, input logic [7:0] r, d, output logic ok);
		logic x1, x2, x3;
		logic [7:0] z;
		LNK.start();
		LNK.xfer({a, 1'b0}, 1'b1, z, x1);
		LNK.xfer(r, 1'b1, z, x2);
		LNK.xfer(d, 1'b1, z, x3);
		LNK.stop();
		ok = !x1 && !x2 && !x3;
		repeat (8) @(posedge i_clk);
	endtask
	// Point, pause for the crossing, repeated start, one byte with no acknowledge
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic x;
		logic [7:0] z;
		LNK.start();
		LNK.xfer({ldc_pkg::TARGET_ADDR, 1'b0}, 1'b1, z, x);
		LNK.xfer(r, 1'b1, z, x);
		repeat (8) @(posedge i_clk);
		LNK.start();
		LNK.xfer({ldc_pkg::TARGET_ADDR, 1'b1}, 1'b1, z, x);
		LNK.xfer(8'hFF, 1'b1, d, x);
		LNK.stop();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		rd(ldc_pkg::OFS_GENERAL, q); `CHK(q, ldc_pkg::RST_GENERAL, "general init")
		rd(ldc_pkg::OFS_IO_CFG, q); `CHK(q, ldc_pkg::RST_IO_CFG, "pin cfg init")
		rd(ldc_pkg::OFS_PRIMARY, q); `CHK(q, ldc_pkg::RST_LEVEL, "primary init")
		rd(ldc_pkg::OFS_SECONDARY, q); `CHK(q, ldc_pkg::RST_LEVEL, "secondary init")
		`CHK({o_primary_sink_enable, o_secondary_sink_enable, o_analog_enable}, 3'h0, "on")
	endtask
	task automatic t_general();
		logic [7:0] g;
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_PRIMARY, 8'hFA, ak);
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_SECONDARY, 8'hE3, ak);
		`CHK(ak, 1'b1, "write not acked")
		foreach (gv[i]) begin
			g = gv[i];
			wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_GENERAL, g, ak);
			`CHK({o_primary_sink_enable, o_secondary_sink_enable, o_primary_level, o_secondary_level},
				{g[0], !g[5] && (g[2] ? g[0] : g[1]), 5'h1A, g[2] ? 5'h1A : 5'h03}, "sinks")
			`CHK({o_step_rate, o_display_bias_mode, o_analog_enable},
				{g[4:3], g[5], g[0] | g[1] | g[5]}, "mode")
			rd(ldc_pkg::OFS_GENERAL, q); `CHK(q, g | 8'hC0, "general readback")
		end
	endtask
	task automatic t_refuse();
		wr(7'h37, ldc_pkg::OFS_PRIMARY, 8'h05, ak); `CHK(ak, 1'b0, "foreign address acked")
		`CHK(o_primary_level, 5'h1A, "foreign write applied")
		wr(ldc_pkg::TARGET_ADDR, 8'h20, 8'h55, ak); `CHK(ak, 1'b1, "unmapped not acked")
		rd(8'h20, q); `CHK(q, ldc_pkg::UNMAPPED_READ, "unmapped read")
	endtask
	task automatic t_pin();
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_GENERAL, 8'h01, ak);
		@(posedge i_clk) pin_low_r <= 1'b1;
		repeat (6) @(posedge i_clk);
		`CHK({o_pin_reset_active, o_analog_enable, o_primary_level}, 7'h40, "pin hold")
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_GENERAL, 8'h01, ak);
		`CHK(o_primary_sink_enable, 1'b0, "write in hold")
		@(posedge i_clk) pin_low_r <= 1'b0;
		repeat (6) @(posedge i_clk);
		`CHK(o_pin_reset_active, 1'b0, "hold stuck")
		rd(ldc_pkg::OFS_GENERAL, q); `CHK(q, 8'hC0, "general after hold")
		rd(ldc_pkg::OFS_IO_CFG, q); `CHK(q, ldc_pkg::PIN_RESET_VALUE, "cfg after hold")
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_IO_CFG, 8'hFB, ak);
		`CHK({o_rstio_oe, i_rstio, o_pin_reset_active}, 3'h4, "pin output low")
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_IO_CFG, 8'h07, ak);
		`CHK({o_rstio_oe, i_rstio}, 2'h1, "pin output released")
		// Input mode: the pin level shows in the value bit and never holds the registers
		wr(ldc_pkg::TARGET_ADDR, ldc_pkg::OFS_IO_CFG, 8'h01, ak);
		@(posedge i_clk) pin_low_r <= 1'b1;
		rd(ldc_pkg::OFS_IO_CFG, q);
		`CHK({q, o_pin_reset_active}, 9'h002, "input mode pin low")
		@(posedge i_clk) pin_low_r <= 1'b0;
		rd(ldc_pkg::OFS_IO_CFG, q);
		`CHK(q, 8'h05, "input mode pin high")
		// Master acknowledges the first byte, so the same register comes again
		LNK.start();
		LNK.xfer({ldc_pkg::TARGET_ADDR, 1'b1}, 1'b1, q, ak);
		LNK.xfer(8'hFF, 1'b0, q, ak);
		LNK.xfer(8'hFF, 1'b1, q, ak);
		LNK.stop();
		`CHK(q, 8'h05, "repeated read byte")
	endtask
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic complete_run();
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// Tests take some 54 us; cut off well past that
	initial begin
		#400000;
		err_total++;
		complete_run();
	end
	initial begin
		i_rst <= 1'b1; // After time zero, so every reset edge is seen
		pin_low_r = 1'b0;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (8) @(posedge i_clk);
		t_reset_values();
		t_general();
		t_refuse();
		t_pin();
		complete_run();
	end
endmodule
`default_nettype wire
